// file: hdl/eectl_host.sv
// Purpose: Two-wire bus host for a byte-wide serial memory, driven
//          by software over Avalon-MM.
// Assumes: Open-drain pins resolved outside; SCL and SDA sampled here.
// Notes:   Writes that end without a nack are followed by acknowledge polling automatically.
// Functional notes
// - Start is SDA falling while SCL high; every command but recovery opens so.
// - Stop is SDA rising while SCL high; ends every sequence.
// - Data changes only while SCL low.
// - Recovery: up to nine clocks watching SDA high, then start.
// - Device word opens with fixed one-zero-one-zero pattern.
// - Eighth device word bit: high reads, low writes.
// - Byte write: word address, one data byte, then stop.
// - Page write carries at most 8 or 16 bytes by variant.
// - Poll with start plus device word until acknowledged; the code gives up after POLL_TRIES tries.
// - Current read: one byte, host withholds acknowledge, stops.
// - Random read: dummy write of address, repeated start, read.
// - Sequential read: host acks each byte but the last.
`timescale 1ns/1ps
module eectl_host
	import eectl_pkg::*;
#(
	parameter int QTR_CYCLES = QTR_CYC
) (
	input  wire logic          SYS_CLK_IN,          // 50 MHz clock
	input  wire logic          RST_N_IN,            // Sync reset, low
	input  wire logic          CE_IN,               // Clock enable
	input  wire logic [AW-1:0] AVS_ADDRESS_IN,      // Byte address
	input  wire logic          AVS_READ_IN,         // Read request
	input  wire logic          AVS_WRITE_IN,        // Write request
	input  wire logic [DW-1:0] AVS_WRITEDATA_IN,    // Write data
	input  wire logic [3:0]    AVS_BYTEENABLE_IN,   // Byte lanes
	output logic      [DW-1:0] AVS_READDATA_OUT,    // Read data
	output logic               AVS_WAITREQUEST_OUT, // Stall
	input  wire logic          SCL_IN,              // Clock pin level
	output logic               SCL_OUT,             // Clock drive value
	output logic               SCL_OE_OUT,          // Pull clock low
	input  wire logic          SDA_IN,              // Data pin level
	output logic               SDA_OUT,             // Data drive value
	output logic               SDA_OE_OUT,          // Pull data low
	output logic               WP_OUT               // Write-protect pin
);
	localparam int QW = $clog2(QTR_CYCLES + 1);
	localparam logic [QW-1:0] QTR_LAST = QW'(QTR_CYCLES - 1);
	localparam logic [TRIES_W-1:0] TRIES_LAST = TRIES_W'(POLL_TRIES - 1);

	eectl_state_t     state;
	eectl_state_t     next_state;
	eectl_mode_t      mode;
	eectl_mode_t      next_mode;
	logic             nack;
	logic             next_nack;
	logic [TRIES_W-1:0] tries;
	logic [TRIES_W-1:0] next_tries;
	logic [2:0]       cfg_var;
	logic [2:0]       cfg_sel;
	logic             cfg_wp;
	logic [WADDR_W-1:0] word_addr;
	logic [CNT_W-1:0] count;
	logic [QW-1:0]    cnt;
	logic [1:0]       q;
	logic [3:0]       bitn;
	logic [CNT_W-1:0] idx;
	logic [7:0]       rx;
	logic [7:0]       buf_mem [BUF_DEPTH];
	logic             resp;
	logic [1:0]       pins_s;

	eectl_sync #(
		.WIDTH(2)
	) u_sync (
		.clk_in   (SYS_CLK_IN),
		.rst_n_in (RST_N_IN),
		.ce_in    (CE_IN),
		.d_in     ({SDA_IN, SCL_IN}),
		.q_out    (pins_s)
	);

	wire scl_s = pins_s[0];
	wire sda_s = pins_s[1];

	// Register bus decode
	wire bus_req  = AVS_READ_IN | AVS_WRITE_IN;
	wire busy     = state != S_IDLE;
	wire bus_wr   = AVS_WRITE_IN & resp & ~busy;
	wire be_lo    = AVS_BYTEENABLE_IN[0];
	wire be_hi    = AVS_BYTEENABLE_IN[1];
	wire hit_ctrl = AVS_ADDRESS_IN == REG_CTRL;
	wire hit_cfg  = AVS_ADDRESS_IN == REG_CONFIG;
	wire hit_addr = AVS_ADDRESS_IN == REG_ADDR;
	wire hit_cnt  = AVS_ADDRESS_IN == REG_COUNT;
	wire hit_sts  = AVS_ADDRESS_IN == REG_STATUS;
	wire hit_data = AVS_ADDRESS_IN[DATA_SEL_BIT];
	wire [BUF_IW-1:0] data_idx = AVS_ADDRESS_IN[DATA_IDX_LSB +: BUF_IW];
	wire [CMD_W-1:0]  cmd_code = AVS_WRITEDATA_IN[CMD_LSB +: CMD_W];
	wire cmd_ok    = (cmd_code >= MD_WRITE) && (cmd_code <= MD_RECOV);
	wire start_cmd = bus_wr & be_lo & hit_ctrl & cmd_ok;

	// Variant geometry
	wire [2:0] var_eff = (cfg_var > VAR_16K) ? VAR_16K : cfg_var;
	wire [WADDR_W-1:0] addr_m = word_addr & (ADDR_FULL >> (VAR_16K - var_eff));
	wire [2:0] pg = addr_m[PAGE_LSB +: 3];
	// Unused select positions carry page bits
	wire [2:0] dev_sel = {(var_eff >= VAR_16K) ? pg[2] : cfg_sel[2],
	                      (var_eff >= VAR_8K)  ? pg[1] : cfg_sel[1],
	                      (var_eff >= VAR_4K)  ? pg[0] : cfg_sel[0]};
	wire [CNT_W-1:0] page_sz = (var_eff >= VAR_4K) ? PAGE_LARGE : PAGE_SMALL;
	wire [CNT_W-1:0] cnt_req = (count == '0) ? ONE_BYTE : count;
	wire [CNT_W-1:0] lim_w = (cnt_req > page_sz) ? page_sz : cnt_req;
	wire [CNT_W-1:0] lim_r = (cnt_req > BUF_LIMIT) ? BUF_LIMIT : cnt_req;
	wire [CNT_W-1:0] lim   = (mode == MD_WRITE) ? lim_w : lim_r;
	wire [CNT_W-1:0] idx_nx = idx + ONE_BYTE;
	wire last = idx_nx == lim;

	// Bit-slot decode
	wire is_start = (state == S_START) || (state == S_RSTART);
	wire is_dev   = (state == S_DEVW) || (state == S_DEVR);
	wire is_tx    = is_dev || (state == S_WADDR) || (state == S_WDATA);
	wire is_bit   = is_tx || (state == S_RDATA) || (state == S_RECOV);
	wire ack_slot = bitn == ACK_SLOT;
	wire [7:0] tx_byte = is_dev ? {DEV_CODE, dev_sel,
	                     (state == S_DEVR) ? DIR_READ : DIR_WRITE}
	                   : (state == S_WADDR) ? addr_m[7:0]
	                   : (state == S_WDATA) ? buf_mem[idx[BUF_IW-1:0]]
	                   : 8'hff;
	wire tx_bit = tx_byte[BIT_MSB - bitn[2:0]];
	// Quarter QC waits for the clock pin to be seen high
	wire tick = (cnt == QTR_LAST) && ((q != QC) || scl_s);
	wire slot_end = tick && (q == QD);
	wire ack_ok = ~sda_s;

	wire scl_drv = is_start ? ((q == QA) || (q == QD))
	             : (state == S_STOP) ? (q <= QB) // Low until data is down
	             : is_bit ? (q <= QB) : 1'b0;
	wire sda_drv = is_start ? (q >= QC)
	             : (state == S_STOP) ? ((q == QB) || (q == QC))
	             : is_tx ? (ack_slot ? 1'b0 : ~tx_bit)
	             : (state == S_RDATA) ? (ack_slot ? ~last : 1'b0)
	             : 1'b0;
	// Data held through QA so it moves only once SCL is low
	wire sda_hold = busy && (q == QA);

	wire [DW-1:0] rd_mux = hit_ctrl ? DW'(mode)
	                     : hit_cfg  ? DW'({cfg_wp, cfg_sel, cfg_var})
	                     : hit_addr ? DW'(addr_m)
	                     : hit_cnt  ? DW'(count)
	                     : hit_sts  ? ((DW'(tries) << STS_TRIES_LSB)
	                                 | (DW'(nack) << STS_NACK_BIT)
	                                 | DW'(busy))
	                     : hit_data ? DW'(buf_mem[data_idx])
	                     : '0;

	assign AVS_WAITREQUEST_OUT = bus_req & ~resp;
	assign SCL_OUT = 1'b0;
	assign SDA_OUT = 1'b0;

	always_comb begin
		next_state = state;
		next_mode  = mode;
		next_nack  = nack;
		next_tries = tries;
		if (start_cmd) begin
			next_mode  = eectl_mode_t'(cmd_code);
			next_state = (cmd_code == MD_RECOV) ? S_RECOV : S_START;
			next_nack  = 1'b0;
			next_tries = '0;
		end else if (slot_end) begin
			case (state)
				S_START: begin
					next_state = (mode == MD_RECOV) ? S_STOP
					           : (mode == MD_CUR) ? S_DEVR : S_DEVW;
				end
				S_RSTART: next_state = S_DEVR;
				S_RECOV: begin
					if (sda_s || ack_slot) begin
						next_state = S_START;
					end
				end
				S_DEVW, S_WADDR, S_DEVR: begin
					if (ack_slot && !ack_ok) begin
						next_nack  = 1'b1;
						next_state = S_STOP;
					end else if (ack_slot) begin
						next_state = (state == S_DEVR) ? S_RDATA
						           : (mode == MD_POLL) ? S_STOP
						           : (state == S_DEVW) ? S_WADDR
						           : (mode == MD_WRITE) ? S_WDATA
						           : S_RSTART;
					end
				end
				S_WDATA: begin
					if (ack_slot && !ack_ok) begin
						next_nack  = 1'b1;
						next_state = S_STOP;
					end else if (ack_slot && last) begin
						next_state = S_STOP;
					end
				end
				S_RDATA: begin
					if (ack_slot && last) begin
						next_state = S_STOP;
					end
				end
				S_STOP: begin
					if (mode == MD_WRITE && !nack) begin
						next_mode  = MD_POLL;
						next_state = S_START;
					end else if (mode == MD_POLL && nack
					             && tries < TRIES_LAST) begin
						// Poll window bounded by the longest write time
						next_tries = tries + 1'b1;
						next_nack  = 1'b0;
						next_state = S_START;
					end else begin
						next_state = S_IDLE;
					end
				end
				default: next_state = S_IDLE;
			endcase
		end
	end

	// Sequencer
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			state <= S_IDLE;
			mode  <= MD_NONE;
			nack  <= 1'b0;
			tries <= '0;
		end else if (CE_IN) begin
			state <= next_state;
			mode  <= next_mode;
			nack  <= next_nack;
			tries <= next_tries;
		end
	end

	// Quarter, bit and byte counters
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			cnt  <= '0;
			q    <= QA;
			bitn <= '0;
			idx  <= '0;
			rx   <= '0;
		end else if (CE_IN) begin
			cnt <= (tick || start_cmd) ? '0
			     : (busy && cnt != QTR_LAST) ? cnt + 1'b1 : cnt;
			if (start_cmd) begin
				q    <= QA;
				bitn <= '0;
				idx  <= '0;
			end else if (tick) begin
				q <= q + 1'b1;
			end
			if (slot_end) begin
				bitn <= (is_bit && !ack_slot && next_state == state)
				        ? bitn + 1'b1 : '0;
				if (state == S_RDATA && !ack_slot) begin
					rx <= {rx[6:0], sda_s};
				end
				if (ack_slot && (state == S_RDATA || state == S_WDATA)) begin
					idx <= idx_nx;
				end
			end
		end
	end

	// Buffer: engine store wins, bus writes only while idle
	always_ff @(posedge SYS_CLK_IN) begin
		if (CE_IN) begin
			if (slot_end && ack_slot && state == S_RDATA) begin
				buf_mem[idx[BUF_IW-1:0]] <= rx;
			end else if (bus_wr && be_lo && hit_data) begin
				buf_mem[data_idx] <= AVS_WRITEDATA_IN[7:0];
			end
		end
	end

	// Configuration registers
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			cfg_var   <= VAR_1K;
			cfg_sel   <= '0;
			cfg_wp    <= 1'b0;
			word_addr <= '0;
			count     <= ONE_BYTE;
		end else if (CE_IN && bus_wr) begin
			if (hit_cfg && be_lo) begin
				cfg_var <= AVS_WRITEDATA_IN[CFG_VAR_LSB +: 3];
				cfg_sel <= AVS_WRITEDATA_IN[CFG_SEL_LSB +: 3];
				cfg_wp  <= AVS_WRITEDATA_IN[CFG_WP_BIT];
			end
			if (hit_addr && be_lo) begin
				word_addr[7:0] <= AVS_WRITEDATA_IN[7:0];
			end
			if (hit_addr && be_hi) begin
				word_addr[WADDR_W-1:PAGE_LSB] <=
					AVS_WRITEDATA_IN[WADDR_W-1:PAGE_LSB];
			end
			if (hit_cnt && be_lo) begin
				count <= AVS_WRITEDATA_IN[CNT_W-1:0];
			end
		end
	end

	// Pins and bus answer
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			SCL_OE_OUT       <= 1'b0;
			SDA_OE_OUT       <= 1'b0;
			WP_OUT           <= 1'b0;
			resp             <= 1'b0;
			AVS_READDATA_OUT <= '0;
		end else if (CE_IN) begin
			SCL_OE_OUT <= scl_drv;
			SDA_OE_OUT <= sda_hold ? SDA_OE_OUT : sda_drv;
			WP_OUT     <= cfg_wp;
			resp       <= bus_req & ~resp;
			if (bus_req && !resp) begin
				AVS_READDATA_OUT <= rd_mux;
			end
		end
	end

	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RST_N_IN || !CE_IN);

	sequence slot_done_s;
		tick && (q == QD);
	endsequence
	sequence ack_done_s;
		slot_done_s ##0 ack_slot;
	endsequence

	start_edge_a: assert property (
		$rose(SDA_OE_OUT) && !SCL_OE_OUT |-> $past(is_start))
		else $error("data fell with clock high outside start");
	stop_edge_a: assert property (
		$fell(SDA_OE_OUT) && !SCL_OE_OUT |-> $past(state) == S_STOP)
		else $error("data rose with clock high outside stop");
	data_hold_a: assert property (
		is_bit && $past(is_bit) && !SCL_OE_OUT && $past(!SCL_OE_OUT)
		|-> $stable(SDA_OE_OUT))
		else $error("data changed while clock high");
	dev_code_a: assert property (
		is_dev |-> tx_byte[DEV_CODE_LSB +: 4] == DEV_CODE)
		else $error("device word pattern wrong");
	dir_bit_a: assert property (
		is_dev |-> tx_byte[DIR_BIT] == (state == S_DEVR))
		else $error("direction bit wrong");
	page_limit_a: assert property (
		state == S_WDATA |-> idx < page_sz)
		else $error("page write longer than page");
	read_ack_a: assert property (
		ack_done_s ##0 (state == S_RDATA) |-> SDA_OE_OUT == !last)
		else $error("read acknowledge wrong");
	recover_cap_a: assert property (
		ack_done_s ##0 (state == S_RECOV) |=> state == S_START)
		else $error("recovery exceeded nine clocks");
	poll_after_a: assert property (
		slot_done_s ##0 (state == S_STOP && mode == MD_WRITE && !nack)
		|=> state == S_START && mode == MD_POLL)
		else $error("no polling after write");
	random_rs_a: assert property (
		ack_done_s ##0 (state == S_WADDR && ack_ok && mode == MD_RAND)
		|=> state == S_RSTART)
		else $error("random read lacks repeated start");
	write_stop_a: assert property (
		ack_done_s ##0 (state == S_WDATA && ack_ok && last)
		|=> state == S_STOP)
		else $error("write not ended by stop");
	bus_answer_a: assert property (
		bus_req && !resp |=> !AVS_WAITREQUEST_OUT)
		else $error("bus answer late");
endmodule

// file: include/eectl_pkg.sv
// Purpose: Shared constants and types for the two-wire memory host.
// Assumes: 50 MHz system clock, byte addresses on the register bus.
// Notes:   Bus quarter-slot of 5 us gives a 50 kHz serial clock.
package eectl_pkg;
	// Timing
	localparam int CLK_PERIOD_NS  = 20;
	localparam int QUARTER_NS     = 5000;
	localparam int QTR_CYC        = (QUARTER_NS + CLK_PERIOD_NS - 1)
	                                / CLK_PERIOD_NS;
	localparam int INTERNAL_WRITE_TIME_NS = 5000000;
	localparam int SLOTS_PER_POLL = 11;
	localparam int QTR_PER_SLOT   = 4;
	localparam int POLL_TRIES     = INTERNAL_WRITE_TIME_NS
	                                / (SLOTS_PER_POLL * QTR_PER_SLOT
	                                   * QUARTER_NS) + 1;

	// Register bus
	localparam int AW = 7;
	localparam int DW = 32;
	localparam logic [AW-1:0] REG_CTRL   = 7'h00;
	localparam logic [AW-1:0] REG_CONFIG = 7'h04;
	localparam logic [AW-1:0] REG_ADDR   = 7'h08;
	localparam logic [AW-1:0] REG_COUNT  = 7'h0c;
	localparam logic [AW-1:0] REG_STATUS = 7'h10;
	localparam int DATA_SEL_BIT = 6;
	localparam int DATA_IDX_LSB = 2;

	// Register fields
	localparam int CMD_LSB       = 0;
	localparam int CMD_W         = 3;
	localparam int CFG_VAR_LSB   = 0;
	localparam int CFG_SEL_LSB   = 3;
	localparam int CFG_WP_BIT    = 6;
	localparam int STS_NACK_BIT  = 1;
	localparam int STS_TRIES_LSB = 8;
	localparam int TRIES_W       = 8;

	// Memory geometry
	localparam int WADDR_W  = 11;
	localparam int PAGE_LSB = 8;
	localparam int BUF_DEPTH = 16;
	localparam int BUF_IW    = 4;
	localparam int CNT_W     = 5;
	localparam logic [WADDR_W-1:0] ADDR_FULL = 11'h7ff;
	localparam logic [CNT_W-1:0] PAGE_SMALL = 5'h08;
	localparam logic [CNT_W-1:0] PAGE_LARGE = 5'h10;
	localparam logic [CNT_W-1:0] BUF_LIMIT  = 5'h10;
	localparam logic [CNT_W-1:0] ONE_BYTE   = 5'h01;
	localparam logic [2:0] VAR_1K  = 3'h0;
	localparam logic [2:0] VAR_4K  = 3'h2;
	localparam logic [2:0] VAR_8K  = 3'h3;
	localparam logic [2:0] VAR_16K = 3'h4;

	// Serial framing
	localparam logic [3:0] DEV_CODE     = 4'ha;
	localparam int         DEV_CODE_LSB = 4;
	localparam int         DIR_BIT      = 0;
	localparam logic       DIR_READ     = 1'b1;
	localparam logic       DIR_WRITE    = 1'b0;
	localparam logic [2:0] BIT_MSB      = 3'h7;
	localparam logic [3:0] ACK_SLOT     = 4'h8;
	localparam logic [1:0] QA = 2'h0;
	localparam logic [1:0] QB = 2'h1;
	localparam logic [1:0] QC = 2'h2;
	localparam logic [1:0] QD = 2'h3;

	typedef enum logic [3:0] {
		S_IDLE   = 4'b0000,
		S_START  = 4'b0001,
		S_DEVW   = 4'b0010,
		S_WADDR  = 4'b0011,
		S_WDATA  = 4'b0100,
		S_RSTART = 4'b0101,
		S_DEVR   = 4'b0110,
		S_RDATA  = 4'b0111,
		S_STOP   = 4'b1000,
		S_RECOV  = 4'b1001
	} eectl_state_t;

	typedef enum logic [2:0] {
		MD_NONE  = 3'b000,
		MD_WRITE = 3'b001,
		MD_CUR   = 3'b010,
		MD_RAND  = 3'b011,
		MD_POLL  = 3'b100,
		MD_RECOV = 3'b101
	} eectl_mode_t;
endpackage

// file: hdl/eectl_sync.sv
// Purpose: Two-stage synchroniser for pins sampled by the system clock.
// Assumes: Inputs are asynchronous to SYS_CLK_IN.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
module eectl_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk_in,   // System clock
	input  wire logic             rst_n_in, // Sync reset, active low
	input  wire logic             ce_in,    // Clock enable
	input  wire logic [WIDTH-1:0] d_in,     // Asynchronous inputs
	output logic      [WIDTH-1:0] q_out     // Synchronised outputs
);
	logic [WIDTH-1:0] meta;

	// Idle bus level is high, so reset to ones
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta  <= '1;
			q_out <= '1;
		end else if (ce_in) begin
			meta  <= d_in;
			q_out <= meta;
		end
	end
endmodule

// file: bench/eectl_mem_model.sv
// Purpose: Behavioural serial memory that answers the two-wire host.
// Assumes: Bus levels resolved by the bench with pull-ups.
// Notes:   Internal write shortened to WR_NS; bytes land on receipt.
`timescale 1ns/1ps
module eectl_mem_model #(
	parameter int WR_NS = 20000
) (
	input  wire logic       scl_in, // Bus clock level
	input  wire logic       sda_in, // Bus data level
	input  wire logic [2:0] var_in, // Size variant
	input  wire logic [2:0] sel_in, // Select pins high/mid/low
	input  wire logic       wp_in,  // Write-protect pin
	output logic            oe_out  // Pull data low
);
	logic [7:0]  mem [0:2047];
	logic [7:0]  sh, cur;
	logic [10:0] ptr, wm;
	logic [3:0]  pm;
	logic [2:0]  pg;
	int          ph, cnt, ns;
	logic        fresh, rd, hack, busy, wrote;

	always_comb begin
		ns = (var_in <= 3'h1) ? 3 : (var_in >= 3'h4) ? 0 : 4 - int'(var_in);
		wm = (var_in >= 3'h4) ? 11'h7ff : 11'((1 << (7 + int'(var_in))) - 1);
		pm = (var_in <= 3'h1) ? 4'h7 : 4'hf;
	end

	initial begin
		for (int i = 0; i < 2048; i++) mem[i] = 8'(i) ^ 8'h5a;
		ph = 0; cnt = 0; ptr = '0; oe_out = 0;
		busy = 0; wrote = 0; fresh = 0; hack = 0; rd = 0; pg = '0;
	end

	// Starts are ignored while the internal write runs
	always @(negedge sda_in) if (scl_in && !busy) begin
		ph = 1; cnt = 0; fresh = 1;
	end

	always @(posedge sda_in) if (scl_in) begin
		ph = 0; oe_out = 0;
		if (wrote) begin
			wrote = 0; busy = 1;
			#(WR_NS) busy = 0;
		end
	end

	always @(posedge scl_in) if (ph != 0) begin
		if (cnt < 8) sh = {sh[6:0], sda_in};
		else hack = !sda_in;
	end

	always @(negedge scl_in) if (fresh) fresh = 0;
	else if (ph != 0) begin
		cnt = cnt + 1;
		if (cnt == 8) case (ph)
			1: if (sh[7:4] == 4'ha &&
				(sh[3:1] >> (3 - ns)) == (sel_in >> (3 - ns))) begin
				pg = sh[3:1] & 3'((1 << (3 - ns)) - 1);
				rd = sh[0]; oe_out = 1;
			end else ph = 0;
			2: begin ptr = {pg, sh} & wm; oe_out = 1; end
			3: begin
				if (!wp_in) mem[ptr] = sh;
				wrote = 1; oe_out = 1;
				ptr = (ptr & ~11'(pm)) | ((ptr + 11'h1) & 11'(pm));
			end
			default: oe_out = 0;
		endcase
		if (cnt == 9) begin
			cnt = 0; oe_out = 0;
			if (ph == 4) ph = hack ? 4 : 0;
			if (ph == 1) ph = rd ? 4 : 2;
			else if (ph == 2) ph = 3;
			if (ph == 4) begin
				cur = mem[ptr];
				ptr = (ptr + 11'h1) & wm;
			end
		end
		if (ph == 4 && cnt < 8) oe_out = !cur[7 - cnt];
	end
endmodule

// file: bench/tb_eectl_host.sv
// Purpose: Self-checking bench for the two-wire memory host.
// Assumes: Quarter slot shortened to 4 cycles; pull-ups on both lines.
// Notes:   Read answers are checked against queued notes.
`timescale 1ns/1ps
module tb_eectl_host;
	import eectl_pkg::*;
	typedef struct { logic [DW-1:0] e; logic [DW-1:0] m; } eectl_note_t;

	logic          clk = 0, rst_n = 0, rd = 0, wr = 0;
	logic [AW-1:0] addr = '0;
	logic [DW-1:0] wdata = '0, rdata, q;
	logic          wreq, scl_oe, sda_oe, mem_oe, wp, scl_o, sda_o;
	logic [2:0]    dev_var = 3'h4;
	logic [7:0]    shadow [0:2047];
	logic [31:0]   seed = 32'hf06d;
	eectl_note_t   notes [$];
	int            n_fail = 0, n_tests = 0, cyc = 0;
	wire           scl = !scl_oe;
	wire           sda = !(sda_oe || mem_oe);

	always #10 clk = !clk;

	eectl_host #(.QTR_CYCLES(4)) dut_u (
		.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1),
		.AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
		.AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hf),
		.AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq),
		.SCL_IN(scl), .SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe),
		.SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .WP_OUT(wp));

	eectl_mem_model #(.WR_NS(20000)) mem_u (.scl_in(scl), .sda_in(sda),
		.var_in(dev_var), .sel_in(3'h5), .wp_in(wp), .oe_out(mem_oe));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic test_done();
		$display("checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// Request held until the edge that sees waitrequest low
	task automatic bus(input logic w, input logic [AW-1:0] a,
		input logic [DW-1:0] d, input logic [DW-1:0] e, input logic [DW-1:0] m);
		if (!w) notes.push_back('{e, m});
		addr <= a; wdata <= d; wr <= w; rd <= !w;
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdata;
		rd <= 0; wr <= 0;
		@(posedge clk);
	endtask

	task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
		bus(1'b1, a, d, '0, '0);
	endtask

	task automatic rd_reg(input logic [AW-1:0] a, input logic [DW-1:0] e,
		input logic [DW-1:0] m);
		bus(1'b0, a, '0, e, m);
	endtask

	task automatic run(input int c);
		wr_reg(REG_CTRL, 32'(c));
		for (int i = 0; i < 3000; i++) begin
			bus(1'b0, REG_STATUS, '0, '0, '0);
			if (q[0] === 1'b0) break;
		end
		check(32'(q[0]), 32'h0);
	endtask

	task automatic rrd(input logic [10:0] a, input int n, input logic [10:0] m);
		wr_reg(REG_ADDR, 32'(a));
		wr_reg(REG_COUNT, 32'(n));
		run(3);
		for (int i = 0; i < n; i++)
			rd_reg(7'(64 + 4 * i), 32'(shadow[(a + i) & m]), 32'hff);
	endtask

	always @(posedge clk) begin
		eectl_note_t n;
		if (rd && wreq === 1'b0) begin
			n = notes.pop_front();
			if (n.m != '0) check(rdata & n.m, n.e);
		end
	end

	// Ceiling well above the expected run of some 12k cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			test_done();
		end
	end

	initial begin
		logic [7:0] b;
		for (int i = 0; i < 2048; i++) shadow[i] = 8'(i) ^ 8'h5a;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		rd_reg(REG_CONFIG, 32'h0, 32'h7f);
		rd_reg(REG_COUNT, 32'h1, 32'h1f);
		wr_reg(7'h14, 32'hffffffff);
		rd_reg(7'h14, 32'h0, 32'hffffffff);
		wr_reg(REG_CONFIG, 32'h4);
		for (int i = 0; i < 16; i++) begin
			b = 8'(xs());
			wr_reg(7'(64 + 4 * i), 32'(b));
			shadow[{7'h1f, 4'(5 + i)}] = b;
		end
		wr_reg(REG_ADDR, 32'h1f5);
		wr_reg(REG_COUNT, 32'h10);
		run(1);
		rd_reg(REG_STATUS, 32'h0, 32'h2);
		rrd(11'h1f0, 16, 11'h7ff);
		wr_reg(REG_COUNT, 32'h1);
		run(2);
		rd_reg(7'h40, 32'(shadow[11'h200]), 32'hff);
		rrd(11'h7fe, 4, 11'h7ff);
		wr_reg(REG_CONFIG, 32'h44);
		// Pin register lags the config write by one edge
		@(posedge clk);
		check(32'(wp), 32'h1);
		check(32'({scl_o, sda_o}), 32'h0);
		wr_reg(7'h40, 32'(~shadow[11'h10]));
		wr_reg(REG_ADDR, 32'h10);
		wr_reg(REG_COUNT, 32'h1);
		run(1);
		wr_reg(REG_CONFIG, 32'h4);
		rrd(11'h10, 1, 11'h7ff);
		dev_var <= 3'h1;
		wr_reg(REG_CONFIG, 32'h1);
		wr_reg(REG_ADDR, 32'h7ff);
		rd_reg(REG_ADDR, 32'hff, 32'h7ff);
		run(2);
		rd_reg(REG_STATUS, 32'h2, 32'h2);
		wr_reg(REG_CONFIG, 32'h29);
		rrd(11'h33, 1, 11'hff);
		rd_reg(REG_STATUS, 32'h0, 32'h2);
		for (int c = 4; c < 6; c++) begin
			run(c);
			rd_reg(REG_STATUS, 32'h0, 32'h3);
		end
		repeat (2) @(posedge clk);
		test_done();
	end
endmodule
